/* File: include/flash_erase_pkg.sv */
// Purpose: Shared constants for the erase and suspend command sequencer.
// Assumes: Byte-wide command frames, MSB first, SPI mode 0 or 3 sampling.
// Notes: Latencies are given in microseconds and turned into ref_clk cycles here.
package flash_erase_pkg;

	// ----------------------------------------------------------------
	// Command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_ERASE_4K = 8'h20;
	localparam logic [7:0] CMD_ERASE_32K = 8'h52;
	localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
	localparam logic [7:0] CMD_CHIP_A = 8'h60;
	localparam logic [7:0] CMD_CHIP_B = 8'hC7;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'hD0;
	localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
	// Opcode of a page program; not decoded, programs start from program_start.
	localparam logic [7:0] CMD_PROGRAM = 8'h02;

	// ----------------------------------------------------------------
	// Address layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_W = 8;
	localparam int BLK4_LSB = 12;
	localparam int BLK32_LSB = 15;
	localparam int BLK64_LSB = 16;
	localparam int ADDR_BYTES = 3;

	// ----------------------------------------------------------------
	// Timing (ref_clk is 25 MHz)
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int BLOCK_ERASE_US = 400;
	localparam int CHIP_ERASE_US = 1000;
	localparam int SUSPEND_US = 20;
	localparam int RESUME_US = 20;
	localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_US * CLK_MHZ;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int RESUME_CYC = RESUME_US * CLK_MHZ;
	localparam int CNT_W = 32;

	// Kind of operation the array engine is busy with.
	typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROGRAM} op_type;

endpackage : flash_erase_pkg

/* File: rtl/serial_flash_erase_suspend.sv */
// Purpose: Erase, chip erase, suspend and resume command sequencer.
// Assumes: Protection, lockdown and erase verify come in as plain ports.
// Notes: All status bits are plain outputs, each straight from a flop.
`timescale 1ns/1ps
module serial_flash_erase_suspend
	import flash_erase_pkg::*;
#(
	parameter int BLOCK_ERASE_CYCLES = flash_erase_pkg::BLOCK_ERASE_CYC,
	parameter int CHIP_ERASE_CYCLES = flash_erase_pkg::CHIP_ERASE_CYC,
	parameter int SUSPEND_CYCLES = flash_erase_pkg::SUSPEND_CYC,
	parameter int RESUME_CYCLES = flash_erase_pkg::RESUME_CYC
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic mosi_pin,
	input wire logic [31:0] sector_protected,
	input wire logic [31:0] sector_locked,
	input wire logic erase_verify_fail,
	input wire logic program_start,
	input wire logic [flash_erase_pkg::ADDR_W-1:0] program_addr,
	input wire logic program_done,
	input wire logic [flash_erase_pkg::ADDR_W-1:0] read_addr,
	output logic write_enable_latch,
	output logic ready_busy_flag,
	output logic erase_program_error_flag,
	output logic program_suspended_flag,
	output logic erase_suspended_flag,
	output logic erase_start,
	output logic [flash_erase_pkg::ADDR_W-1:0] erase_base,
	output logic [flash_erase_pkg::ADDR_W-1:0] erase_size,
	output logic read_undefined
);
	import flash_erase_pkg::*;

	// ----------------------------------------------------------------
	// Frame receiver
	// ----------------------------------------------------------------
	logic [7:0] rx_byte; // Last whole byte received.
	logic rx_valid; // Pulse per received byte.
	logic rx_start; // Pulse at select fall.
	logic rx_end; // Pulse at select rise.
	logic rx_aligned; // Release fell on a byte boundary.

	serial_frame_rx u_rx (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin),
		.mosi_pin(mosi_pin),
		.byte_data(rx_byte),
		.byte_valid(rx_valid),
		.frame_start(rx_start),
		.frame_end(rx_end),
		.frame_aligned(rx_aligned)
	);

	// ----------------------------------------------------------------
	// Command capture
	// ----------------------------------------------------------------
	logic [7:0] opcode_ff; // First byte of the frame.
	logic [2:0] nbytes_ff; // Bytes seen, saturating at four.
	logic [ADDR_W-1:0] addr_ff; // Address bytes, MSB first.

	// Bytes past the third address byte are dropped here.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			opcode_ff <= 8'h00;
			nbytes_ff <= 3'h0;
			addr_ff <= '0;
		end
		else if (rx_start)
			nbytes_ff <= 3'h0;
		else if (rx_valid && nbytes_ff != 3'h4)
		begin
			nbytes_ff <= nbytes_ff + 3'h1;
			if (nbytes_ff == 3'h0)
				opcode_ff <= rx_byte;
			else
				addr_ff <= {addr_ff[15:0], rx_byte};
		end
	end

	// Decode of what the frame asks for.
	function automatic logic [ADDR_W-1:0] blk_size(input logic [7:0] op);
		blk_size = (op == CMD_ERASE_4K) ? 24'h00_1000 :
			(op == CMD_ERASE_32K) ? 24'h00_8000 : 24'h01_0000;
	endfunction : blk_size

	wire have_op = nbytes_ff != 3'h0; // An earlier frame's opcode never counts.
	wire is_blk = have_op && ((opcode_ff == CMD_ERASE_4K) || (opcode_ff == CMD_ERASE_32K)
		|| (opcode_ff == CMD_ERASE_64K));
	wire is_chip = have_op && ((opcode_ff == CMD_CHIP_A) || (opcode_ff == CMD_CHIP_B));
	wire good_end = rx_end && rx_aligned && have_op;
	wire bad_end = rx_end && (!rx_aligned || !have_op);
	wire addr_full = nbytes_ff >= 3'(1 + ADDR_BYTES);
	wire [ADDR_W-1:0] size_sel = blk_size(opcode_ff);
	wire [ADDR_W-1:0] base_sel = addr_ff & ~(size_sel - 24'h00_0001);
	wire [4:0] tgt_sector = addr_ff[20:16];
	wire tgt_prot = sector_protected[tgt_sector] | sector_locked[tgt_sector];
	wire any_prot = (|sector_protected) | (|sector_locked);

	// ----------------------------------------------------------------
	// Operation engine
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_ERASE, S_PROG, S_SUSPENDING, S_RESUMING} state_type;
	state_type state_ff;
	logic [CNT_W-1:0] cnt_ff; // Remaining cycles of the timed phase.
	logic [CNT_W-1:0] erase_left_ff; // Erase cycles left when suspended.
	op_type susp_op_ff; // Operation being halted or resumed.
	logic [4:0] es_sector_ff; // Sector of the suspended erase.
	logic [4:0] ps_sector_ff; // Sector of the suspended program.
	logic [4:0] run_sector_ff; // Sector of the running operation.

	wire in_susp = program_suspended_flag | erase_suspended_flag;
	wire wel_ok = write_enable_latch;
	wire blk_cmd = good_end && is_blk && state_ff == S_IDLE;
	wire blk_conflict = program_suspended_flag && tgt_sector == ps_sector_ff;
	// Block and chip erase are never allowed while anything is suspended.
	wire blk_go = blk_cmd && wel_ok && addr_full && !tgt_prot && !in_susp;
	wire blk_fail = state_ff == S_IDLE && is_blk && rx_end && !in_susp
		&& (!rx_aligned || !addr_full || tgt_prot);
	wire blk_psusp = blk_cmd && program_suspended_flag && blk_conflict;
	wire chip_go = good_end && is_chip && state_ff == S_IDLE && wel_ok
		&& !any_prot && !in_susp;
	wire chip_fail = state_ff == S_IDLE && is_chip && !in_susp
		&& ((rx_end && have_op && !rx_aligned) || (good_end && any_prot));
	// Program into an erase-suspended sector aborts; a different sector runs.
	wire prog_bad = program_start && erase_suspended_flag
		&& program_addr[20:16] == es_sector_ff;
	wire prog_go = program_start && state_ff == S_IDLE && !program_suspended_flag && !prog_bad;
	wire susp_go = good_end && opcode_ff == CMD_SUSPEND
		&& (state_ff == S_ERASE || state_ff == S_PROG);
	wire res_go = good_end && opcode_ff == CMD_RESUME && state_ff == S_IDLE && in_susp;
	wire wren_go = good_end && opcode_ff == CMD_WR_ENABLE
		&& !program_suspended_flag;
	wire cnt_zero = cnt_ff == '0;
	wire [CNT_W-1:0] cnt_dec = cnt_ff - 32'h0000_0001;
	wire erase_fin = state_ff == S_ERASE && cnt_zero;

	// Main sequencing of timed phases.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= S_IDLE;
			cnt_ff <= '0;
			erase_left_ff <= '0;
			susp_op_ff <= OP_NONE;
			run_sector_ff <= 5'h00;
			es_sector_ff <= 5'h00;
			ps_sector_ff <= 5'h00;
			program_suspended_flag <= 1'b0;
			erase_suspended_flag <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				S_IDLE:
				begin
					if (blk_go && !blk_conflict)
					begin
						state_ff <= S_ERASE;
						cnt_ff <= CNT_W'(BLOCK_ERASE_CYCLES - 1);
						run_sector_ff <= tgt_sector;
					end
					else if (chip_go)
					begin
						state_ff <= S_ERASE;
						cnt_ff <= CNT_W'(CHIP_ERASE_CYCLES - 1);
					end
					else if (prog_go)
					begin
						state_ff <= S_PROG;
						run_sector_ff <= program_addr[20:16];
					end
					else if (res_go)
					begin
						state_ff <= S_RESUMING;
						cnt_ff <= CNT_W'(RESUME_CYCLES - 1);
						// A suspended program always goes first.
						susp_op_ff <= program_suspended_flag ? OP_PROGRAM : OP_ERASE;
					end
				end
				S_ERASE:
				begin
					cnt_ff <= cnt_dec;
					if (susp_go)
					begin
						state_ff <= S_SUSPENDING;
						erase_left_ff <= cnt_ff;
						susp_op_ff <= OP_ERASE;
						cnt_ff <= CNT_W'(SUSPEND_CYCLES - 1);
					end
					else if (cnt_zero)
						state_ff <= S_IDLE;
				end
				S_PROG:
				begin
					if (susp_go)
					begin
						state_ff <= S_SUSPENDING;
						susp_op_ff <= OP_PROGRAM;
						cnt_ff <= CNT_W'(SUSPEND_CYCLES - 1);
					end
					else if (program_done)
						state_ff <= S_IDLE;
				end
				S_SUSPENDING:
				begin
					cnt_ff <= cnt_dec;
					if (cnt_zero)
					begin
						// Halted: raise the matching flag and go ready.
						state_ff <= S_IDLE;
						if (susp_op_ff == OP_ERASE)
						begin
							erase_suspended_flag <= 1'b1;
							es_sector_ff <= run_sector_ff;
						end
						else
						begin
							program_suspended_flag <= 1'b1;
							ps_sector_ff <= run_sector_ff;
						end
					end
				end
				S_RESUMING:
				begin
					cnt_ff <= cnt_dec;
					if (cnt_zero)
					begin
						// Back to the halted work; its flag drops.
						if (susp_op_ff == OP_PROGRAM)
						begin
							program_suspended_flag <= 1'b0;
							state_ff <= S_PROG;
							run_sector_ff <= ps_sector_ff;
						end
						else
						begin
							erase_suspended_flag <= 1'b0;
							state_ff <= S_ERASE;
							cnt_ff <= erase_left_ff;
							run_sector_ff <= es_sector_ff;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Status and array outputs
	// ----------------------------------------------------------------
	wire wel_clear = blk_fail || blk_psusp || chip_fail || prog_bad
		|| (blk_go && !blk_conflict) || chip_go;
	wire busy_next = state_ff != S_IDLE && !(state_ff == S_SUSPENDING && cnt_zero);
	wire [4:0] rd_sector = read_addr[20:16];

	// Status flags and erase request toward the array.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			write_enable_latch <= 1'b0;
			ready_busy_flag <= 1'b0;
			erase_program_error_flag <= 1'b0;
			erase_start <= 1'b0;
			erase_base <= '0;
			erase_size <= '0;
			read_undefined <= 1'b0;
		end
		else
		begin
			// Clearing at erase launch satisfies "before it finishes".
			if (wren_go)
				write_enable_latch <= 1'b1;
			else if (wel_clear)
				write_enable_latch <= 1'b0;
			ready_busy_flag <= busy_next;
			// Verify result is sampled as the timed erase completes.
			if (blk_go || chip_go)
				erase_program_error_flag <= 1'b0;
			else if (erase_fin && erase_verify_fail)
				erase_program_error_flag <= 1'b1;
			erase_start <= (blk_go && !blk_conflict) || chip_go;
			if (blk_go)
			begin
				erase_base <= base_sel;
				erase_size <= size_sel;
			end
			else if (chip_go)
			begin
				erase_base <= '0;
				erase_size <= '1;
			end
			// Reads into a halted sector return undefined data.
			read_undefined <= (erase_suspended_flag && rd_sector == es_sector_ff)
				|| (program_suspended_flag && rd_sector == ps_sector_ff);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_no_wel_no_erase: assert property (@(posedge ref_clk) disable iff (!arst_n)
		erase_start |-> $past(write_enable_latch))
		else $error("Erase started with latch clear.");
	chk_erase_busy: assert property (@(posedge ref_clk) disable iff (!arst_n)
		erase_start |-> ##1 ready_busy_flag)
		else $error("Busy not shown during erase.");
	chk_bad_end_noop: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(bad_end && state_ff == S_IDLE) |=> !erase_start)
		else $error("Erase after misaligned release.");
	chk_wel_clear_abort: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(blk_fail && !wren_go) |=> !write_enable_latch)
		else $error("Latch kept after aborted erase.");
	chk_wren_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
		wren_go |=> write_enable_latch)
		else $error("Write enable not set.");
	logic [CNT_W-1:0] susp_age_ff; // Halt cycles, counted so no long delay range is needed.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			susp_age_ff <= '0;
		else
			susp_age_ff <= (state_ff == S_SUSPENDING) ? susp_age_ff + 32'h0000_0001 : '0;
	end
	chk_suspend_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(state_ff == S_SUSPENDING && susp_op_ff == OP_ERASE
		&& susp_age_ff == CNT_W'(SUSPEND_CYCLES - 1)) |=> erase_suspended_flag)
		else $error("Erase suspend flag not raised within the latency.");
	chk_prog_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(res_go && program_suspended_flag) |=> susp_op_ff == OP_PROGRAM)
		else $error("Erase resumed before program.");
	chk_base_aligned: assert property (@(posedge ref_clk) disable iff (!arst_n)
		erase_start |-> (erase_base & (erase_size - 24'h00_0001)) == '0)
		else $error("Erase base not block aligned.");
endmodule : serial_flash_erase_suspend

/* File: rtl/serial_frame_rx.sv */
// Purpose: Samples the serial clock, select and data pins and frames bytes.
// Assumes: Pins are asynchronous to ref_clk and much slower than it.
// Notes: Data is taken on the rising edge of the serial clock, MSB first.
`timescale 1ns/1ps
module serial_frame_rx (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic mosi_pin,
	output logic [7:0] byte_data,
	output logic byte_valid,
	output logic frame_start,
	output logic frame_end,
	output logic frame_aligned
);
	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [2:0] meta_ff; // First stage, read only by the second stage.
	logic [2:0] sync_ff; // Second stage, safe to use.
	logic sclk_d_ff; // Delayed clock level for edge detection.
	logic cs_d_ff; // Delayed select level for edge detection.
	logic [2:0] bit_cnt_ff; // Bits shifted into the current byte.
	logic [7:0] shift_ff; // Byte under assembly.

	// Two flops for each pin before any logic sees it.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_ff <= 3'b010;
			sync_ff <= 3'b010;
		end
		else
		begin
			meta_ff <= {sclk_pin, cs_n_pin, mosi_pin};
			sync_ff <= meta_ff;
		end
	end

	wire sclk_s = sync_ff[2];
	wire cs_s = sync_ff[1];
	wire mosi_s = sync_ff[0];
	wire sclk_rise = sclk_s & ~sclk_d_ff;
	wire cs_fall = ~cs_s & cs_d_ff;
	wire cs_rise = cs_s & ~cs_d_ff;
	wire shift_now = sclk_rise & ~cs_s;
	wire byte_done = shift_now & (bit_cnt_ff == 3'h7);

	// Shift bits in while selected; the count restarts at each new frame.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_d_ff <= 1'b0;
			cs_d_ff <= 1'b1;
			bit_cnt_ff <= 3'h0;
			shift_ff <= 8'h00;
			byte_data <= 8'h00;
			byte_valid <= 1'b0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
			frame_aligned <= 1'b0;
		end
		else
		begin
			sclk_d_ff <= sclk_s;
			cs_d_ff <= cs_s;
			byte_valid <= byte_done;
			frame_start <= cs_fall;
			frame_end <= cs_rise;
			frame_aligned <= (bit_cnt_ff == 3'h0);
			if (cs_fall)
				bit_cnt_ff <= 3'h0;
			else if (shift_now)
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (shift_now)
				shift_ff <= {shift_ff[6:0], mosi_s};
			if (byte_done)
				byte_data <= {shift_ff[6:0], mosi_s};
		end
	end
endmodule : serial_frame_rx

/* File: test/serial_flash_erase_suspend_tb_top.sv */
// Purpose: Self-checking bench for the erase and suspend sequencer.
// Assumes: Shortened latencies; outputs settle about 5 cycles after release.
// Notes: The timeout counter ends the run if any wait hangs.
`timescale 1ns/1ps
module serial_flash_erase_suspend_tb_top;
	import flash_erase_pkg::*;
	// Short counts keep the run brief but leave room to suspend an erase.
	localparam int BLK_CYC = 400;
	localparam int CHP_CYC = 400;
	localparam int SUS_CYC = 20;
	localparam int RES_CYC = 20;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic sclk_pin, cs_n_pin, mosi_pin;
	logic [31:0] sector_protected = '0;
	logic [31:0] sector_locked = '0;
	logic erase_verify_fail = 1'b0;
	logic program_start = 1'b0;
	logic [ADDR_W-1:0] program_addr = '0;
	logic program_done = 1'b0;
	logic [ADDR_W-1:0] read_addr = '0;
	logic write_enable_latch, ready_busy_flag, erase_program_error_flag;
	logic program_suspended_flag, erase_suspended_flag, erase_start, read_undefined;
	logic [ADDR_W-1:0] erase_base, erase_size;
	logic [23:0] seen_base, seen_size;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int starts = 0;

	spi_host_model host (.ref_clk(ref_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
		.mosi_pin(mosi_pin));
	serial_flash_erase_suspend #(.BLOCK_ERASE_CYCLES(BLK_CYC), .CHIP_ERASE_CYCLES(CHP_CYC),
		.SUSPEND_CYCLES(SUS_CYC), .RESUME_CYCLES(RES_CYC)) dut (.ref_clk(ref_clk),
		.arst_n(arst_n), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .mosi_pin(mosi_pin),
		.sector_protected(sector_protected), .sector_locked(sector_locked),
		.erase_verify_fail(erase_verify_fail), .program_start(program_start),
		.program_addr(program_addr), .program_done(program_done), .read_addr(read_addr),
		.write_enable_latch(write_enable_latch), .ready_busy_flag(ready_busy_flag),
		.erase_program_error_flag(erase_program_error_flag),
		.program_suspended_flag(program_suspended_flag),
		.erase_suspended_flag(erase_suspended_flag), .erase_start(erase_start),
		.erase_base(erase_base), .erase_size(erase_size), .read_undefined(read_undefined));

	always #20 ref_clk = ~ref_clk;

	// Counts launches, keeps the launched region and cuts a hang short.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (erase_start === 1'b1)
		begin
			starts++;
			seen_base = erase_base;
			seen_size = erase_size;
		end
		if (cycles == 60000)
		begin
			failures++;
			$display("unexpected at %0t: timeout", $time);
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wait_cyc

	// One frame, then time for the answer to land.
	task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nbits);
		host.send_frame({op, addr, 8'h5A}, nbits);
		wait_cyc(12);
	endtask : frame

	task automatic wen();
		frame(CMD_WR_ENABLE, 24'h00_0000, 8);
	endtask : wen

	task automatic prog_pulse(input logic [23:0] addr);
		@(posedge ref_clk);
		program_addr <= addr;
		program_start <= 1'b1;
		@(posedge ref_clk);
		program_start <= 1'b0;
		wait_cyc(4);
	endtask : prog_pulse

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_block_sizes();
		logic [7:0] ops [3];
		logic [23:0] sz [3];
		int n;
		ops = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K};
		sz = '{24'h00_1000, 24'h00_8000, 24'h01_0000};
		for (int i = 0; i < 3; i++)
		begin
			wen();
			check(write_enable_latch, 1, "latch set");
			n = starts;
			// The last size also carries a trailing byte that must be ignored.
			frame(ops[i], 24'hAA_BBCC, (i == 2) ? 40 : 32);
			check(starts, n + 1, "launch");
			check(seen_size, sz[i], "size");
			check(seen_base, 24'hAA_BBCC & ~(sz[i] - 1), "base");
			check(write_enable_latch, 0, "latch after launch");
			check(ready_busy_flag, 1, "busy");
			wait_cyc(BLK_CYC - 100);
			check(ready_busy_flag, 1, "still busy");
			wait_cyc(120);
			check(ready_busy_flag, 0, "done");
		end
	endtask : test_block_sizes

	// No latch, short address, torn release, protected target, locked target.
	task automatic test_refusals();
		int nb [4];
		int n;
		nb = '{24, 29, 32, 32};
		n = starts;
		frame(CMD_ERASE_4K, 24'h00_0000, 32);
		check(starts, n, "no latch");
		for (int k = 0; k < 4; k++)
		begin
			if (k == 2)
				sector_protected[3] <= 1'b1;
			if (k == 3)
			begin
				sector_protected[3] <= 1'b0;
				sector_locked[3] <= 1'b1;
			end
			wen();
			frame(CMD_ERASE_64K, 24'h03_0000, nb[k]);
			check(starts, n, "refused erase");
			check(write_enable_latch, 0, "latch after abort");
			check(ready_busy_flag, 0, "idle after abort");
		end
		sector_locked[3] <= 1'b0;
	endtask : test_refusals

	task automatic test_chip();
		logic [7:0] ops [2];
		int n;
		ops = '{CMD_CHIP_A, CMD_CHIP_B};
		for (int i = 0; i < 2; i++)
		begin
			erase_verify_fail <= (i == 1);
			wen();
			n = starts;
			frame(ops[i], 24'h00_0000, 8);
			check(starts, n + 1, "chip launch");
			check({seen_base, seen_size} == {24'h00_0000, 24'hFF_FFFF}, 1, "chip region");
			wait_cyc(CHP_CYC + 30);
			check(ready_busy_flag, 0, "chip done");
			check(erase_program_error_flag, i, "error flag");
		end
		erase_verify_fail <= 1'b0;
		n = starts;
		sector_locked[31] <= 1'b1;
		wen();
		frame(CMD_CHIP_A, 24'h00_0000, 8);
		check({starts == n, write_enable_latch}, 2, "chip locked");
		sector_locked[31] <= 1'b0;
		wen();
		frame(CMD_CHIP_B, 24'h00_0000, 5);
		check(starts, n, "chip short opcode");
		frame(CMD_CHIP_B, 24'h00_0000, 13);
		check({starts == n, write_enable_latch}, 2, "chip torn");
	endtask : test_chip

	task automatic test_suspend();
		int n;
		wen();
		frame(CMD_ERASE_64K, 24'h05_0000, 32);
		frame(CMD_SUSPEND, 24'h00_0000, 7);
		check(erase_suspended_flag, 0, "torn suspend");
		frame(CMD_SUSPEND, 24'h00_0000, 16);
		wait_cyc(SUS_CYC);
		check(erase_suspended_flag, 1, "erase suspended");
		check(ready_busy_flag, 0, "ready in suspend");
		read_addr <= 24'h05_1234;
		wait_cyc(3);
		check(read_undefined, 1, "suspended read");
		read_addr <= 24'h06_0000;
		wait_cyc(3);
		check(read_undefined, 0, "other read");
		wen();
		n = starts;
		frame(CMD_CHIP_A, 24'h00_0000, 8);
		check({starts == n, write_enable_latch}, 3, "chip in suspend");
		prog_pulse(24'h05_0100);
		check({write_enable_latch, ready_busy_flag}, 0, "program conflict");
		prog_pulse(24'h07_0000);
		check(ready_busy_flag, 1, "program runs");
		frame(CMD_SUSPEND, 24'h00_0000, 8);
		wait_cyc(SUS_CYC);
		check({program_suspended_flag, erase_suspended_flag}, 3, "both suspended");
		wen();
		check(write_enable_latch, 0, "latch held");
		frame(CMD_RESUME, 24'h00_0000, 8);
		wait_cyc(RES_CYC);
		check({program_suspended_flag, ready_busy_flag}, 1, "program resumed");
		check(erase_suspended_flag, 1, "erase waits");
		@(posedge ref_clk);
		program_done <= 1'b1;
		@(posedge ref_clk);
		program_done <= 1'b0;
		wait_cyc(4);
		check(ready_busy_flag, 0, "program done");
		frame(CMD_RESUME, 24'h00_0000, 8);
		wait_cyc(RES_CYC);
		check({erase_suspended_flag, ready_busy_flag}, 1, "erase resumed");
		frame(CMD_SUSPEND, 24'h00_0000, 8);
		wait_cyc(SUS_CYC);
		check(erase_suspended_flag, 1, "erase suspended again");
		arst_n <= 1'b0;
		wait_cyc(3);
		arst_n <= 1'b1;
		wait_cyc(3);
		check({erase_suspended_flag, ready_busy_flag}, 0, "reset drops suspend");
	endtask : test_suspend

	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// Main sequence: reset, then every scenario in turn.
	initial
	begin
		wait_cyc(5);
		arst_n <= 1'b1;
		wait_cyc(2);
		test_block_sizes();
		test_refusals();
		test_chip();
		test_suspend();
		stop_test();
	end
endmodule : serial_flash_erase_suspend_tb_top

/* File: test/spi_host_model.sv */
// Purpose: Host controller model that clocks command frames into the block.
// Assumes: Serial clock idles low and data is sent MSB first.
// Notes: While deselected the data line shows the inverse of its last bit.
`timescale 1ns/1ps
module spi_host_model (
	input wire logic ref_clk,
	output logic sclk_pin,
	output logic cs_n_pin,
	output logic mosi_pin
);
	// Half of the 320 ns serial period, in ref_clk cycles.
	localparam int HALF = 4;

	// Idle lines at time zero.
	initial
	begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
		mosi_pin = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame driver
	// ------------------------------------------------------------
	// Sends the top nbits; a count off a byte boundary tears the frame.
	task automatic send_frame(input logic [39:0] data, input int nbits);
		int i;
		@(posedge ref_clk);
		cs_n_pin <= 1'b0;
		for (i = 0; i < nbits; i++)
		begin
			// Data moves with the falling edge, half a period before the rise.
			mosi_pin <= data[39 - i];
			repeat (HALF) @(posedge ref_clk);
			sclk_pin <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			sclk_pin <= 1'b0;
		end
		repeat (HALF) @(posedge ref_clk);
		cs_n_pin <= 1'b1;
		mosi_pin <= ~mosi_pin;
		repeat (2 * HALF) @(posedge ref_clk);
	endtask : send_frame
endmodule : spi_host_model
